//--- inc/ctic_pkg.sv
// Constants, types and register map of the overlay control register bank
package ctic_pkg;
    // Register indexes; byte address is four times the index
    localparam logic [7:0] IDX_MODE = 8'h80;
    localparam logic [7:0] IDX_START = 8'h81;
    localparam logic [7:0] IDX_XLO = 8'h82;
    localparam logic [7:0] IDX_XHI = 8'h83;
    localparam logic [7:0] IDX_YLO = 8'h84;
    localparam logic [7:0] IDX_YHI = 8'h85;
    localparam logic [7:0] IDX_BLUE0 = 8'h86;
    localparam logic [7:0] IDX_STATUS = 8'h8f;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 9;

    // Field layout and reset values
    localparam int SIGN_BIT = 7;
    localparam int POS_HI_W = 2;
    localparam int POS_W = 10;
    localparam int SPOS_W = 11;
    localparam int BLUE_W = 5;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [9:0] NEG_MAG_MAX = 10'h03f;

    // Start encoding
    localparam int MEM_AW = 24;
    localparam logic [7:0] START_MAX = 8'ha0;
    localparam logic [MEM_AW-1:0] START_SMALL_BYTES = 24'h000400;
    localparam int START_UNIT_SHIFT = 13;

    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        CTIC_OFF = 2'b00,
        CTIC_CURSOR = 2'b01,
        CTIC_INK = 2'b10,
        CTIC_RSVD = 2'b11
    } ctic_mode_t;

    typedef struct packed {
        logic cursor_en;
        logic ink_en;
        logic [MEM_AW-1:0] start_addr;
        logic start_ok;
        logic signed [SPOS_W-1:0] xpos;
        logic signed [SPOS_W-1:0] ypos;
        logic [BLUE_W-1:0] blue0;
    } ctic_ovl_t;
endpackage : ctic_pkg

//--- core/ctic_regs.sv
// Overlay cursor/ink control register bank with AXI4-Lite slave
`timescale 1ns/1ns
// Functional notes
// R1: Mode 00 off, 01 cursor, 10 ink, 11 reserved.
// R2: Software zeroes both position registers while ink is selected.
// R3: Start code zero places image at memory size minus 1024.
// R4: Start code n places image at size minus n*8192; above range invalid.
// R5: New start code applies at next vertical non-display period.
// R6: Vertical high byte bit 7 is sign; one means negative.
// R7: Software keeps negative magnitude at 63 or less.
// R8: Horizontal position is ten bits: low byte plus two high bits.
// R9: Vertical position is ten bits: low byte plus two high bits.
// R10: Positions count only in cursor mode.
// R11: Other position bytes wait for vertical high write and blanking.
// R12: Vertical high byte applies at next blanking with pending bytes.
// R13: Horizontal sign acts the same; negative magnitude clamped to 63.
// R14: Reserved mode behaves as overlay disabled.
// R15: Blue colour zero holds five bits.
module ctic_regs
    import ctic_pkg::*;
#(
    parameter int AW = 12
) (
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Write address and data
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // Write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Display timing and memory size
    input wire logic vnd,
    input wire logic [MEM_AW-1:0] mem_size,
    // Overlay settings to the layer
    output ctic_ovl_t ovl
);

    logic [7:0] mode_r;
    logic [7:0] start_r;
    logic [7:0] xlo_r;
    logic [7:0] xhi_r;
    logic [7:0] ylo_r;
    logic [7:0] yhi_r;
    logic [7:0] blue_r;
    logic [7:0] start_a_r;
    logic [7:0] xlo_a_r;
    logic [7:0] xhi_a_r;
    logic [7:0] ylo_a_r;
    logic [7:0] yhi_a_r;
    logic pos_pend_r;
    logic start_pend_r;
    logic vnd_d_r;
    logic aw_v_r;
    logic w_v_r;
    logic bvalid_r;
    logic rvalid_r;
    logic [AW-1:0] aw_addr_r;
    logic [7:0] w_data_r;
    logic w_strb_r;
    logic [1:0] bresp_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;
    ctic_ovl_t ovl_r;

    // Unmapped or misaligned addresses answer with an error
    function automatic logic map_hit(input logic [AW-1:0] a);
        logic [7:0] i;
        i = a[IDX_MSB:IDX_LSB];
        map_hit = (a[1:0] == 2'b00) && ((a >> (IDX_MSB + 1)) == '0) &&
                  (((i >= IDX_MODE) && (i <= IDX_BLUE0)) || i == IDX_STATUS);
    endfunction : map_hit

    // Sign and magnitude to two's complement, negative side clamped
    function automatic logic signed [SPOS_W-1:0] pos_of(
        input logic [7:0] lo, input logic [7:0] hi);
        logic [POS_W-1:0] mag;
        mag = {hi[POS_HI_W-1:0], lo};
        if (hi[SIGN_BIT]) begin
            if (mag > NEG_MAG_MAX) begin
                mag = NEG_MAG_MAX;
            end
            pos_of = -$signed({1'b0, mag});
        end else begin
            pos_of = $signed({1'b0, mag});
        end
    endfunction : pos_of

    // Bus decode
    wire [7:0] aw_idx = aw_addr_r[IDX_MSB:IDX_LSB];
    wire [7:0] ar_idx = s_axi_araddr[IDX_MSB:IDX_LSB];
    wire aw_take = ce & s_axi_awvalid & ~aw_v_r;
    wire w_take = ce & s_axi_wvalid & ~w_v_r;
    wire wr_go = ce & aw_v_r & w_v_r & ~bvalid_r;
    wire wr_ok = map_hit(aw_addr_r);
    // Narrow registers sit in lane 0; writes without it only answer
    wire wr_en = wr_go & wr_ok & w_strb_r;
    wire ar_take = ce & s_axi_arvalid & ~rvalid_r;
    wire rd_ok = map_hit(s_axi_araddr);

    wire we_mode = wr_en & (aw_idx == IDX_MODE);
    wire we_start = wr_en & (aw_idx == IDX_START);
    wire we_xlo = wr_en & (aw_idx == IDX_XLO);
    wire we_xhi = wr_en & (aw_idx == IDX_XHI);
    wire we_ylo = wr_en & (aw_idx == IDX_YLO);
    wire we_yhi = wr_en & (aw_idx == IDX_YHI);
    wire we_blue = wr_en & (aw_idx == IDX_BLUE0);

    // Blanking start: latch pending values into the active set
    wire vnd_rise = ce & vnd & ~vnd_d_r;
    wire pos_apply = vnd_rise & pos_pend_r; // R11 R12
    wire start_apply = vnd_rise & start_pend_r; // R5
    // Write in the apply cycle keeps pending for the next blanking
    wire pos_pend_nxt = we_yhi | (pos_pend_r & ~pos_apply); // R11
    wire start_pend_nxt = we_start | (start_pend_r & ~start_apply);

    // Reserved bits read back as zero
    wire [7:0] mask_hi = 8'h83;
    wire [7:0] rd_byte =
        (ar_idx == IDX_MODE) ? {6'h00, mode_r[1:0]} :
        (ar_idx == IDX_START) ? start_r :
        (ar_idx == IDX_XLO) ? xlo_r :
        (ar_idx == IDX_XHI) ? (xhi_r & mask_hi) :
        (ar_idx == IDX_YLO) ? ylo_r :
        (ar_idx == IDX_YHI) ? (yhi_r & mask_hi) :
        (ar_idx == IDX_BLUE0) ? {3'h0, blue_r[BLUE_W-1:0]} :
        {5'h00, vnd, start_pend_r, pos_pend_r};

    // Effective mode; reserved code means off
    wire [1:0] mode_w = mode_r[1:0];
    wire cur_on = (mode_w == CTIC_CURSOR); // R1 R14
    wire ink_on = (mode_w == CTIC_INK); // R1 R14
    wire [MEM_AW-1:0] start_off = (start_a_r == 8'h00) ? START_SMALL_BYTES
        : MEM_AW'({start_a_r, {START_UNIT_SHIFT{1'b0}}}); // R3 R4
    wire start_ok_w = (start_a_r <= START_MAX); // R4
    wire signed [SPOS_W-1:0] xpos_w = pos_of(xlo_a_r, xhi_a_r); // R8 R13
    wire signed [SPOS_W-1:0] ypos_w = pos_of(ylo_a_r, yhi_a_r); // R6 R9

    ctic_ovl_t ovl_nxt;
    assign ovl_nxt.cursor_en = cur_on;
    assign ovl_nxt.ink_en = ink_on;
    assign ovl_nxt.start_addr = mem_size - start_off; // R3 R4
    assign ovl_nxt.start_ok = start_ok_w;
    // Position is ignored unless cursor mode is selected
    assign ovl_nxt.xpos = cur_on ? xpos_w : '0; // R10
    assign ovl_nxt.ypos = cur_on ? ypos_w : '0; // R10
    assign ovl_nxt.blue0 = blue_r[BLUE_W-1:0]; // R15

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_r <= REG_RST;
            start_r <= REG_RST;
            xlo_r <= REG_RST;
            xhi_r <= REG_RST;
            ylo_r <= REG_RST;
            yhi_r <= REG_RST;
            blue_r <= REG_RST;
        end else begin
            // Staging copies for start and position, live mode and blue; readback shows them at once
            if (we_mode) begin
                mode_r <= w_data_r; // R1
            end
            if (we_start) begin
                start_r <= w_data_r;
            end
            if (we_xlo) begin
                xlo_r <= w_data_r;
            end
            if (we_xhi) begin
                xhi_r <= w_data_r;
            end
            if (we_ylo) begin
                ylo_r <= w_data_r;
            end
            if (we_yhi) begin
                yhi_r <= w_data_r;
            end
            if (we_blue) begin
                blue_r <= w_data_r; // R15
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_a_r <= REG_RST;
            xlo_a_r <= REG_RST;
            xhi_a_r <= REG_RST;
            ylo_a_r <= REG_RST;
            yhi_a_r <= REG_RST;
            pos_pend_r <= 1'b0;
            start_pend_r <= 1'b0;
            vnd_d_r <= 1'b0;
            ovl_r <= '0;
        end else if (ce) begin
            vnd_d_r <= vnd;
            pos_pend_r <= pos_pend_nxt;
            start_pend_r <= start_pend_nxt;
            ovl_r <= ovl_nxt;
            // Active copies only move at blanking start
            if (start_apply) begin
                start_a_r <= start_r; // R5
            end
            if (pos_apply) begin // R11 R12
                xlo_a_r <= xlo_r;
                xhi_a_r <= xhi_r;
                ylo_a_r <= ylo_r;
                yhi_a_r <= yhi_r;
            end
        end
    end

    // AXI4-Lite slave; address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_v_r <= 1'b0;
            w_v_r <= 1'b0;
            aw_addr_r <= '0;
            w_data_r <= REG_RST;
            w_strb_r <= 1'b0;
        end else if (ce) begin
            if (aw_take) begin
                aw_v_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_v_r <= 1'b0;
            end
            // Only lane 0 is kept; upper lanes are dropped
            if (w_take) begin
                w_v_r <= 1'b1;
                w_data_r <= s_axi_wdata[7:0];
                w_strb_r <= s_axi_wstrb[0];
            end else if (wr_go) begin
                w_v_r <= 1'b0;
            end
        end
    end

    // Write answer once both halves are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else if (ce) begin
            if (wr_go) begin
                bvalid_r <= 1'b1;
                bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // Read answer one cycle after the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= '0;
        end else if (ce) begin
            if (ar_take) begin
                rvalid_r <= 1'b1;
                rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
                rdata_r <= rd_ok ? {24'h000000, rd_byte} : 32'h00000000;
            end else if (s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    assign s_axi_awready = ce & ~aw_v_r;
    assign s_axi_wready = ce & ~w_v_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = ce & ~rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
    assign ovl = ovl_r;

endmodule : ctic_regs

//--- sim/ctic_regs_checker.sv
// Bus and overlay timing checks for the overlay register bank
`timescale 1ns/1ns
module ctic_regs_checker
    import ctic_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    // Timing and overlay
    input wire logic vnd,
    input wire ctic_ovl_t ovl
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_wr_ans;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("no write answer");
    property p_bdone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_bdone: assert property (p_bdone) else $error("bvalid stuck");
    property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("no read answer");
    property p_rrefuse; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_rrefuse: assert property (p_rrefuse) else $error("read not held off");
    property p_mode_excl; !(ovl.cursor_en && ovl.ink_en); endproperty
    a_mode_excl: assert property (p_mode_excl) else $error("two modes");
    property p_pos_gate; !ovl.cursor_en |-> ovl.xpos == 0 && ovl.ypos == 0;
    endproperty
    a_pos_gate: assert property (p_pos_gate) else $error("pos leak");
    property p_clamp; ovl.xpos >= -11'sd63 && ovl.ypos >= -11'sd63;
    endproperty
    a_clamp: assert property (p_clamp) else $error("neg pos");
    // Guard on reset history: first computed value may land after release
    property p_start_apply;
        $changed(ovl.start_addr) && $past(aresetn, 2)
            |-> $past(vnd, 2) && !$past(vnd, 3);
    endproperty
    a_start_apply: assert property (p_start_apply) else $error("early");
    property p_pos_apply;
        $changed({ovl.xpos, ovl.ypos}) && $stable(ovl.cursor_en)
            |-> $past(vnd, 2) && !$past(vnd, 3);
    endproperty
    a_pos_apply: assert property (p_pos_apply) else $error("pos");
endmodule : ctic_regs_checker

bind ctic_regs ctic_regs_checker u_chk (.*);

//--- sim/testbench.sv
// Self-checking bench for the overlay register bank
`timescale 1ns/1ns
module testbench;
    import ctic_pkg::*;
    localparam logic [23:0] MEM = 24'h140000;
    logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1, vnd = 1'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, dat;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [23:0] mem_size = MEM;
    ctic_ovl_t ovl;
    int bad_count = 0, num_checks = 0;

    ctic_regs dut (.*);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        @(posedge aclk);
        s_axi_awaddr <= {2'h0, i, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask : wr
    task automatic rd(input logic [7:0] i);
        @(posedge aclk);
        s_axi_araddr <= {2'h0, i, 2'h0};
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        rsp = s_axi_rresp;
        dat = s_axi_rdata;
        s_axi_rready <= 1'h0;
    endtask : rd
    // Blanking long enough for apply plus the output flop
    task automatic pulse;
        @(posedge aclk);
        vnd <= 1'h1;
        repeat (3) @(posedge aclk);
        vnd <= 1'h0;
        @(posedge aclk);
    endtask : pulse
    task automatic t_modes;
        for (int m = 0; m < 4; m++) begin
            wr(IDX_MODE, 8'(m));
            repeat (3) @(posedge aclk);
            chk(ovl.cursor_en, m == 1);
            chk(ovl.ink_en, m == 2);
            rd(IDX_MODE);
            chk(dat, 32'(m));
        end
    endtask : t_modes
    task automatic t_start;
        wr(IDX_START, 8'h02);
        pulse();
        chk(ovl.start_addr, MEM - 24'h004000);
        wr(IDX_START, 8'h00);
        repeat (4) @(posedge aclk);
        chk(ovl.start_addr, MEM - 24'h004000);
        pulse();
        chk(ovl.start_addr, MEM - 24'h000400);
        wr(IDX_START, 8'ha0);
        pulse();
        chk({ovl.start_ok, ovl.start_addr}, 32'h1000000);
        wr(IDX_START, 8'ha1);
        pulse();
        chk(ovl.start_ok, 32'h0);
    endtask : t_start
    task automatic t_pos;
        wr(IDX_MODE, 8'h01);
        wr(IDX_XLO, 8'h34);
        wr(IDX_XHI, 8'h02);
        wr(IDX_YLO, 8'h56);
        pulse();
        chk(ovl.xpos, 32'h0);
        wr(IDX_YHI, 8'h01);
        repeat (4) @(posedge aclk);
        chk(ovl.ypos, 32'h0);
        rd(IDX_STATUS);
        chk(dat, 32'h1);
        pulse();
        chk(ovl.xpos, 32'h234);
        chk(ovl.ypos, 32'h156);
        wr(IDX_XLO, 8'h10);
        wr(IDX_XHI, 8'h80);
        wr(IDX_YLO, 8'h3f);
        wr(IDX_YHI, 8'h80);
        pulse();
        chk(ovl.xpos, 32'hfffffff0);
        chk(ovl.ypos, 32'hffffffc1);
        wr(IDX_MODE, 8'h03);
        repeat (3) @(posedge aclk);
        chk({ovl.xpos, ovl.ypos}, 32'h0);
    endtask : t_pos
    task automatic t_misc;
        wr(IDX_BLUE0, 8'hff);
        repeat (3) @(posedge aclk);
        chk(ovl.blue0, 32'h1f);
        rd(IDX_BLUE0);
        chk(dat, 32'h1f);
        wr(8'h90, 8'h55);
        chk(rsp, RESP_SLVERR);
        rd(8'h90);
        chk(rsp, RESP_SLVERR);
        chk(dat, 32'h0);
    endtask : t_misc
    task automatic report_and_stop;
        if (bad_count == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        forever #25 aclk = ~aclk;
    end
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        t_modes();
        t_start();
        t_pos();
        t_misc();
        report_and_stop();
    end
    // About 200 cycles of traffic; a generous margin before giving up
    initial begin
        repeat (5000) @(posedge aclk);
        bad_count++;
        report_and_stop();
    end
endmodule : testbench
